// *** design/bus_fabric_pkg.sv ***
// Shared types and constants for the core memory bus fabric.
// Assumes a single synchronous clock shared by core, data memories and peripherals.
package bus_fabric_pkg;

    localparam int PROG_ADDR_W = 21;
    localparam int DATA_ADDR_W = 24;
    localparam int CORE_DATA_W = 32;
    localparam int NARROW_W = 16;

    // Word-address map of the data space (word = 16 bits)
    localparam logic [23:0] RAM_BASE = 24'h000000;
    localparam logic [23:0] RAM_WORDS = 24'h002000;
    localparam logic [23:0] DFLASH_BASE = 24'h004000;
    localparam logic [23:0] DFLASH_WORDS = 24'h001000;
    localparam logic [23:0] PERIPH_BASE = 24'h00F000;
    localparam logic [23:0] PERIPH_WORDS = 24'h001000;
    // Program space: flash low, program RAM high
    localparam logic [20:0] PRAM_BASE = 21'h1F0000;
    localparam int PRAM_AW = 11;
    // Must cover RAM_WORDS, or the upper RAM half aliases the lower one
    localparam int DRAM_AW = 13;

    localparam logic [CORE_DATA_W-1:0] RESET_DATA = 32'h00000000;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG
    } access_size_e;

    typedef enum logic [1:0] {
        TGT_NONE,
        TGT_RAM,
        TGT_DFLASH,
        TGT_PERIPH
    } target_e;

    // Primary data access request from the core
    typedef struct packed {
        logic rd;
        logic wr;
        access_size_e size;
        logic [DATA_ADDR_W-1:0] addr;
        logic [CORE_DATA_W-1:0] wdata;
    } primary_req_s;

    // Secondary (word-only) read request
    typedef struct packed {
        logic rd;
        logic [DATA_ADDR_W-1:0] addr;
    } secondary_req_s;

    // Program memory request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [PROG_ADDR_W-1:0] addr;
        logic [NARROW_W-1:0] wdata;
    } program_req_s;

    // Peripheral bus request towards the bridge
    typedef struct packed {
        logic rd;
        logic wr;
        logic [DATA_ADDR_W-1:0] addr;
        logic [NARROW_W-1:0] wdata;
    } periph_req_s;

    // Flash array access (data reads/writes bypass the peripheral bus)
    typedef struct packed {
        logic rd;
        logic wr;
        logic prog_space;
        logic [DATA_ADDR_W-1:0] addr;
        logic [NARROW_W-1:0] wdata;
    } flash_req_s;

    function automatic logic in_window(input logic [23:0] a, input logic [23:0] base,
                                       input logic [23:0] words);
        in_window = (a >= base) && (a < base + words);
    endfunction : in_window

    function automatic target_e decode_data(input logic [23:0] a);
        if (in_window(a, RAM_BASE, RAM_WORDS)) begin
            decode_data = TGT_RAM;
        end else if (in_window(a, DFLASH_BASE, DFLASH_WORDS)) begin
            decode_data = TGT_DFLASH;
        end else if (in_window(a, PERIPH_BASE, PERIPH_WORDS)) begin
            decode_data = TGT_PERIPH;
        end else begin
            decode_data = TGT_NONE;
        end
    endfunction : decode_data

endpackage : bus_fabric_pkg

// *** design/data_ram_dual.sv ***
// Data RAM: one 32-bit primary port with byte lanes, one 16-bit read-only secondary port.
// Assumes word addressing; read data come out of a register one cycle after the request.
`timescale 1ns/10ps
module data_ram_dual import bus_fabric_pkg::*; #(
    parameter int AW = DRAM_AW
) (
    input wire logic i_sys_clk,
    input wire logic [AW-1:0] i_p_addr,
    input wire logic i_p_wr,
    input wire logic [3:0] i_p_lane,
    input wire logic [31:0] i_p_wdata,
    output logic [31:0] o_p_rdata,
    input wire logic [AW-1:0] i_s_addr,
    output logic [15:0] o_s_rdata
);
    logic [15:0] mem [0:(1<<AW)-1];
    logic [AW-1:0] p_hi;

    assign p_hi = i_p_addr + AW'(1);

    // Two independent ports so primary and secondary reads never stall each other
    always_ff @(posedge i_sys_clk) begin
        if (i_p_wr) begin
            if (i_p_lane[0]) mem[i_p_addr][7:0] <= i_p_wdata[7:0];
            if (i_p_lane[1]) mem[i_p_addr][15:8] <= i_p_wdata[15:8];
            if (i_p_lane[2]) mem[p_hi][7:0] <= i_p_wdata[23:16];
            if (i_p_lane[3]) mem[p_hi][15:8] <= i_p_wdata[31:24];
        end
        o_p_rdata <= {mem[p_hi], mem[i_p_addr]};
        o_s_rdata <= mem[i_s_addr];
    end
endmodule : data_ram_dual

// *** design/program_ram.sv ***
// Program RAM: single 16-bit port for fetches and program-space writes.
// Assumes word addressing; read data registered.
`timescale 1ns/10ps
module program_ram import bus_fabric_pkg::*; #(
    parameter int AW = PRAM_AW
) (
    input wire logic i_sys_clk,
    input wire logic [AW-1:0] i_addr,
    input wire logic i_wr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata
);
    logic [15:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_sys_clk) begin
        if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule : program_ram

// *** design/core_memory_bus_fabric.sv ***
// Core-side bus fabric: program, primary data, secondary data and peripheral paths.
// Assumes the data flash and the peripheral bridge answer combinationally in the request
// cycle and program flash answers in the cycle after, like the on-chip RAMs, so no access needs wait states.
// Contract
// - Program reads return 16-bit data per address
// - Program writes use low 16 write bits
// - Program address bus is 21 bits
// - Primary reads return 32 bits on core_read_bus
// - Primary writes take up to 32 bits
// - Primary bus: byte/word/long, also peripheral registers
// - Secondary bus word-only reads, 16-bit return
// - Peripheral bus 16-bit, zero wait states
// - Peripheral writes from core_write, reads to core_read
// - Byte accesses force address MSB to zero
// - Primary RAM port 32-bit, others 16-bit
// - Flash control via peripheral bus, data direct
`timescale 1ns/10ps
module core_memory_bus_fabric import bus_fabric_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Program memory interface
    input wire program_req_s i_program_req,
    output logic [15:0] o_program_read_bus,
    // Core write bus (program and primary data share it)
    input wire logic [31:0] i_core_write_bus,
    // Primary data interface
    input wire logic i_primary_rd,
    input wire logic i_primary_wr,
    input wire access_size_e i_primary_size,
    input wire logic [23:0] i_primary_addr_bus,
    output logic [31:0] o_core_read_bus,
    // Secondary data interface
    input wire secondary_req_s i_secondary_req,
    output logic [15:0] o_secondary_read_bus,
    // Peripheral bus towards the bridge
    output periph_req_s o_peripheral_bus,
    input wire logic [15:0] i_peripheral_rdata,
    // Flash arrays inside the flash module (data path only)
    output flash_req_s o_flash_req,
    input wire logic [15:0] i_flash_rdata,
    input wire logic [15:0] i_flash_prog_rdata
);

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_RAM,
        SRC_FLASH,
        SRC_PERIPH
    } read_src_e;

    typedef struct packed {
        read_src_e p_src;
        access_size_e p_size;
        logic p_odd;
        read_src_e s_src;
        logic prog_from_ram;
        logic [15:0] periph_data;
        logic [15:0] flash_data;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [23:0] p_addr;
    target_e p_tgt;
    target_e s_tgt;
    logic [3:0] lane;
    logic [31:0] wdata_aligned;
    logic [31:0] ram_p_rdata;
    logic [15:0] ram_s_rdata;
    logic [15:0] pram_rdata;
    logic prog_is_ram;
    logic p_flash_use;
    logic s_flash_use;
    logic [31:0] p_word;

    // Byte addresses live in the lower half; the top bit is discarded for bytes
    always_comb begin
        p_addr = i_primary_addr_bus;
        if (i_primary_size == SIZE_BYTE) begin
            p_addr[DATA_ADDR_W-1] = 1'b0;
        end
    end

    // Byte accesses carry a byte address; word and long carry a word address
    logic [23:0] p_word_addr;
    assign p_word_addr = (i_primary_size == SIZE_BYTE) ? {1'b0, p_addr[23:1]} : p_addr;

    assign p_tgt = decode_data(p_word_addr);
    assign s_tgt = decode_data(i_secondary_req.addr);
    assign prog_is_ram = i_program_req.addr >= PRAM_BASE;

    // Byte lanes and write data placement on the 32-bit RAM port
    always_comb begin
        lane = 4'h0;
        wdata_aligned = i_core_write_bus;
        case (i_primary_size)
            SIZE_BYTE: begin
                lane = p_addr[0] ? 4'h2 : 4'h1;
                wdata_aligned = {16'h0000, i_core_write_bus[7:0], i_core_write_bus[7:0]};
            end
            SIZE_WORD: lane = 4'h3;
            SIZE_LONG: lane = 4'hF;
            default: lane = 4'h0;
        endcase
    end

    data_ram_dual #(.AW(DRAM_AW)) u_data_ram (
        .i_sys_clk(i_sys_clk),
        .i_p_addr(p_word_addr[DRAM_AW-1:0]),
        .i_p_wr(i_primary_wr && (p_tgt == TGT_RAM)),
        .i_p_lane(lane),
        .i_p_wdata(wdata_aligned),
        .o_p_rdata(ram_p_rdata),
        .i_s_addr(i_secondary_req.addr[DRAM_AW-1:0]),
        .o_s_rdata(ram_s_rdata)
    );

    program_ram #(.AW(PRAM_AW)) u_program_ram (
        .i_sys_clk(i_sys_clk),
        .i_addr(i_program_req.addr[PRAM_AW-1:0]),
        .i_wr(i_program_req.wr && prog_is_ram),
        .i_wdata(i_core_write_bus[15:0]),
        .o_rdata(pram_rdata)
    );

    // Peripheral bus: 16 bits from the core write bus, same clock, no wait states
    always_comb begin
        o_peripheral_bus.rd = i_primary_rd && (p_tgt == TGT_PERIPH);
        o_peripheral_bus.wr = i_primary_wr && (p_tgt == TGT_PERIPH);
        o_peripheral_bus.addr = p_word_addr;
        o_peripheral_bus.wdata = i_core_write_bus[15:0];
    end

    // Flash data path: program space first, then primary, then secondary.
    // Flash control registers are only reachable over the peripheral bus.
    assign p_flash_use = (i_primary_rd || i_primary_wr) && (p_tgt == TGT_DFLASH);
    assign s_flash_use = i_secondary_req.rd && (s_tgt == TGT_DFLASH) && !p_flash_use;
    always_comb begin
        o_flash_req.prog_space = (i_program_req.rd || i_program_req.wr) && !prog_is_ram;
        o_flash_req.rd = i_program_req.rd && !prog_is_ram;
        o_flash_req.wr = i_program_req.wr && !prog_is_ram;
        o_flash_req.addr = {3'b000, i_program_req.addr};
        o_flash_req.wdata = i_core_write_bus[15:0];
        if (!o_flash_req.prog_space) begin
            if (p_flash_use) begin
                o_flash_req.rd = i_primary_rd;
                o_flash_req.wr = i_primary_wr;
                o_flash_req.addr = p_word_addr;
            end else if (s_flash_use) begin
                o_flash_req.rd = 1'b1;
                o_flash_req.addr = i_secondary_req.addr;
            end
        end
    end

    // Track which source answers each pending read
    always_comb begin
        st_d = st_q;
        st_d.p_src = SRC_NONE;
        st_d.s_src = SRC_NONE;
        st_d.p_size = i_primary_size;
        st_d.p_odd = p_addr[0] && (i_primary_size == SIZE_BYTE);
        st_d.prog_from_ram = prog_is_ram;
        st_d.periph_data = i_peripheral_rdata;
        st_d.flash_data = i_flash_rdata;
        if (i_primary_rd) begin
            case (p_tgt)
                TGT_RAM: st_d.p_src = SRC_RAM;
                TGT_DFLASH: st_d.p_src = o_flash_req.prog_space ? SRC_NONE : SRC_FLASH;
                TGT_PERIPH: st_d.p_src = SRC_PERIPH;
                default: st_d.p_src = SRC_NONE;
            endcase
        end
        if (i_secondary_req.rd) begin
            case (s_tgt)
                TGT_RAM: st_d.s_src = SRC_RAM;
                TGT_DFLASH: st_d.s_src = s_flash_use && !o_flash_req.prog_space ?
                    SRC_FLASH : SRC_NONE;
                default: st_d.s_src = SRC_NONE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Select the primary word, then shift bytes down and zero the rest
    always_comb begin
        case (st_q.p_src)
            SRC_RAM: p_word = ram_p_rdata;
            SRC_FLASH: p_word = {16'h0000, st_q.flash_data};
            SRC_PERIPH: p_word = {16'h0000, st_q.periph_data};
            default: p_word = RESET_DATA;
        endcase
        case (st_q.p_size)
            SIZE_BYTE: o_core_read_bus = {24'h000000,
                st_q.p_odd ? p_word[15:8] : p_word[7:0]};
            SIZE_WORD: o_core_read_bus = {16'h0000, p_word[15:0]};
            default: o_core_read_bus = p_word;
        endcase
    end

    always_comb begin
        case (st_q.s_src)
            SRC_RAM: o_secondary_read_bus = ram_s_rdata;
            SRC_FLASH: o_secondary_read_bus = st_q.flash_data;
            default: o_secondary_read_bus = 16'h0000;
        endcase
    end

    // Program data: registered RAM output, or the flash array answer passed straight through
    assign o_program_read_bus = st_q.prog_from_ram ? pram_rdata : i_flash_prog_rdata;

endmodule : core_memory_bus_fabric

// *** bench/fabric_far_side.sv ***
// Model of the flash arrays and the peripheral bridge beside the fabric.
// Assumes one clock; answers carry fixed patterns so the bench can predict them.
`timescale 1ns/10ps
module fabric_far_side import bus_fabric_pkg::*; #(
    parameter logic [15:0] PERIPH_DATA = 16'hA5C3,
    parameter logic [15:0] FLASH_DATA = 16'h5E71,
    parameter logic [15:0] PROG_DATA = 16'h9B24
) (
    input logic i_sys_clk,
    input logic i_reset_n,
    input periph_req_s i_peripheral_bus,
    input flash_req_s i_flash_req,
    output logic [15:0] o_peripheral_rdata,
    output logic [15:0] o_flash_rdata,
    output logic [15:0] o_flash_prog_rdata
);
    // Register answers land in the request cycle, so the core never waits
    assign o_peripheral_rdata = i_peripheral_bus.rd ? PERIPH_DATA : ~PERIPH_DATA;
    // Data flash is read straight from the array, not over the register bus
    assign o_flash_rdata = (i_flash_req.rd && !i_flash_req.prog_space) ? FLASH_DATA : ~FLASH_DATA;
    // Lines keep toggling between reads so a stale value never looks right
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flash_prog_rdata <= 16'h0000;
        end else if (i_flash_req.rd && i_flash_req.prog_space) begin
            o_flash_prog_rdata <= PROG_DATA;
        end else begin
            o_flash_prog_rdata <= ~o_flash_prog_rdata;
        end
    end
endmodule : fabric_far_side

// *** bench/core_memory_bus_fabric_properties.sv ***
// Port assertions for the core memory bus fabric.
// Assumes the package word map and a read answer exactly one cycle after the request.
`timescale 1ns/10ps
module fabric_props import bus_fabric_pkg::*; (
    input logic i_sys_clk,
    input logic i_reset_n,
    input program_req_s i_program_req,
    input logic [15:0] o_program_read_bus,
    input logic [31:0] i_core_write_bus,
    input logic i_primary_rd,
    input logic i_primary_wr,
    input access_size_e i_primary_size,
    input logic [23:0] i_primary_addr_bus,
    input logic [31:0] o_core_read_bus,
    input secondary_req_s i_secondary_req,
    input logic [15:0] o_secondary_read_bus,
    input periph_req_s o_peripheral_bus,
    input logic [15:0] i_peripheral_rdata,
    input flash_req_s o_flash_req,
    input logic [15:0] i_flash_rdata,
    input logic [15:0] i_flash_prog_rdata
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    logic wd, per, dfl, hole, pbusy;
    logic [15:0] cw_lo;
    assign cw_lo = i_core_write_bus[15:0];
    assign wd = i_primary_size == SIZE_WORD;
    assign per = wd && i_primary_addr_bus >= 24'h00F000 && i_primary_addr_bus <= 24'h00FFFF;
    assign dfl = wd && i_primary_addr_bus >= 24'h004000 && i_primary_addr_bus <= 24'h004FFF;
    assign hole = wd && i_primary_addr_bus >= 24'h002000 && i_primary_addr_bus <= 24'h003FFF;
    assign pbusy = i_program_req.rd || i_program_req.wr;

    a_periph_write_now: assert property (i_primary_wr && per |-> o_peripheral_bus.wr &&
        o_peripheral_bus.wdata == cw_lo) else $error("peripheral write lost");
    a_periph_read_now: assert property (i_primary_rd && per |-> o_peripheral_bus.rd)
        else $error("peripheral read not issued");
    a_periph_read_data: assert property (i_primary_rd && per |=>
        o_core_read_bus == {16'h0000, $past(i_peripheral_rdata)}) else $error("bad periph data");
    a_periph_bus_quiet: assert property (!i_primary_rd && !i_primary_wr |->
        !o_peripheral_bus.rd && !o_peripheral_bus.wr) else $error("stray peripheral access");
    a_prog_flash_pass: assert property (i_program_req.rd && i_program_req.addr < PRAM_BASE
        |-> o_flash_req.rd && o_flash_req.prog_space &&
        o_flash_req.addr == {3'b000, i_program_req.addr}
        ##1 o_program_read_bus == i_flash_prog_rdata) else $error("bad program flash data");
    a_byte_msb_drop: assert property (i_primary_wr && i_primary_size == SIZE_BYTE &&
        i_primary_addr_bus[22:0] >= 23'h01E000 && i_primary_addr_bus[22:0] <= 23'h01FFFF
        |-> o_peripheral_bus.wr && o_peripheral_bus.addr == {2'b00, i_primary_addr_bus[22:1]})
        else $error("byte address top bit kept");
    a_prog_write_back: assert property (i_program_req.wr && i_program_req.addr >= PRAM_BASE
        ##1 i_program_req.rd && i_program_req.addr == $past(i_program_req.addr)
        |=> o_program_read_bus == $past(cw_lo, 2)) else $error("program write data wrong");
    a_dflash_read: assert property (i_primary_rd && dfl && !pbusy |-> o_flash_req.rd &&
        !o_flash_req.prog_space ##1 o_core_read_bus == {16'h0000, $past(i_flash_rdata)})
        else $error("data flash read wrong");
    a_hole_reads_zero: assert property (i_primary_rd && hole |=> o_core_read_bus == 32'h0)
        else $error("unmapped primary read not zero");
    a_sec_hole_zero: assert property (i_secondary_req.rd &&
        i_secondary_req.addr >= 24'h002000 && i_secondary_req.addr <= 24'h003FFF
        |=> o_secondary_read_bus == 16'h0)
        else $error("unmapped secondary read not zero");
endmodule : fabric_props

bind core_memory_bus_fabric fabric_props chk_u (.i_sys_clk, .i_reset_n, .i_program_req,
    .o_program_read_bus, .i_core_write_bus, .i_primary_rd, .i_primary_wr, .i_primary_size,
    .i_primary_addr_bus, .o_core_read_bus, .i_secondary_req, .o_secondary_read_bus,
    .o_peripheral_bus, .i_peripheral_rdata, .o_flash_req, .i_flash_rdata, .i_flash_prog_rdata);

// *** bench/core_memory_bus_fabric_tb.sv ***
// Self-checking bench for the core memory bus fabric.
// Assumes the far-side model answers with its fixed patterns; inputs move on falling edges.
`timescale 1ns/10ps
module core_memory_bus_fabric_tb;
    import bus_fabric_pkg::*;
    localparam logic [15:0] PD = 16'hA5C3;
    localparam logic [15:0] FD = 16'h5E71;
    localparam logic [15:0] GD = 16'h9B24;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    program_req_s preq = '0;
    secondary_req_s sreq = '0;
    logic [31:0] cwb = '0;
    logic p_rd = 1'b0;
    logic p_wr = 1'b0;
    access_size_e p_sz = SIZE_WORD;
    logic [23:0] p_a = '0;
    logic [31:0] crb;
    logic [15:0] prb, srb, per_rd, fl_rd, fp_rd;
    periph_req_s pbus;
    flash_req_s freq;
    int error_cnt = 0;
    int check_count = 0;

    core_memory_bus_fabric dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_program_req(preq),
        .o_program_read_bus(prb), .i_core_write_bus(cwb), .i_primary_rd(p_rd),
        .i_primary_wr(p_wr), .i_primary_size(p_sz), .i_primary_addr_bus(p_a),
        .o_core_read_bus(crb), .i_secondary_req(sreq), .o_secondary_read_bus(srb),
        .o_peripheral_bus(pbus), .i_peripheral_rdata(per_rd), .o_flash_req(freq),
        .i_flash_rdata(fl_rd), .i_flash_prog_rdata(fp_rd));
    fabric_far_side #(.PERIPH_DATA(PD), .FLASH_DATA(FD), .PROG_DATA(GD)) far_u (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_peripheral_bus(pbus), .i_flash_req(freq),
        .o_peripheral_rdata(per_rd), .o_flash_rdata(fl_rd), .o_flash_prog_rdata(fp_rd));

    always #10 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request stays up until the next drive or idle, so results can be peeked meanwhile
    task automatic prim(input logic rd, input logic wr, input access_size_e sz,
                        input logic [23:0] a, input logic [31:0] wd);
        @(negedge clk);
        p_rd = rd;
        p_wr = wr;
        p_sz = sz;
        p_a = a;
        cwb = wd;
        sreq = '0;
        preq = '0;
        #2;
    endtask : prim

    // Struct write field gets the upper half so a wrong data source shows up
    task automatic prog(input logic rd, input logic wr, input logic [20:0] a,
                        input logic [31:0] wd);
        @(negedge clk);
        p_rd = 1'b0;
        p_wr = 1'b0;
        cwb = wd;
        preq = '{rd: rd, wr: wr, addr: a, wdata: wd[31:16]};
        #2;
    endtask : prog

    task automatic idle;
        @(negedge clk);
        p_rd = 1'b0;
        p_wr = 1'b0;
        sreq = '0;
        preq = '0;
        #2;
    endtask : idle

    task automatic test_ram;
        prim(0, 1, SIZE_WORD, 24'h000010, 32'hFFFF1234);
        prim(0, 1, SIZE_LONG, 24'h000012, 32'hCAFEBEEF);
        // Upper RAM half must not alias onto word 0x10
        prim(0, 1, SIZE_WORD, 24'h001010, 32'h00009876);
        prim(1, 0, SIZE_LONG, 24'h000012, 32'h0);
        prim(1, 0, SIZE_WORD, 24'h000010, 32'h0);
        sreq = '{rd: 1'b1, addr: 24'h000013};
        check("long read", crb, 32'hCAFEBEEF);
        idle;
        check("word read", crb, 32'h00001234);
        check("secondary read", {16'h0000, srb}, 32'h0000CAFE);
        $display("test_ram done");
    endtask : test_ram

    task automatic test_byte;
        prim(0, 1, SIZE_WORD, 24'h000020, 32'h0000A55A);
        prim(0, 1, SIZE_BYTE, 24'h800041, 32'h0000003C);
        prim(1, 0, SIZE_WORD, 24'h000020, 32'h0);
        prim(1, 0, SIZE_BYTE, 24'h800040, 32'h0);
        check("byte merge", crb, 32'h00003C5A);
        idle;
        check("byte read", crb, 32'h0000005A);
        $display("test_byte done");
    endtask : test_byte

    task automatic test_periph;
        prim(0, 1, SIZE_WORD, 24'h00F010, 32'hDEAD5678);
        check("periph write", {14'h0, pbus.wr, pbus.rd, pbus.wdata}, 32'h00025678);
        prim(1, 0, SIZE_WORD, 24'h00F020, 32'h0);
        check("periph read", {30'h0, pbus.wr, pbus.rd}, 32'h1);
        check("periph addr", {8'h00, pbus.addr}, 32'h0000F020);
        idle;
        check("periph data", crb, {16'h0000, PD});
        prim(0, 1, SIZE_BYTE, 24'h81E021, 32'h0000003C);
        check("periph byte", {7'h00, pbus.wr, pbus.addr}, 32'h0100F010);
        $display("test_periph done");
    endtask : test_periph

    task automatic test_program;
        prog(0, 1, 21'h1F0005, 32'h77774321);
        prog(1, 0, 21'h1F0005, 32'h0);
        prog(1, 0, 21'h000100, 32'h0);
        check("program ram", {16'h0000, prb}, 32'h00004321);
        idle;
        check("program flash", {16'h0000, prb}, {16'h0000, GD});
        $display("test_program done");
    endtask : test_program

    task automatic test_flash_hole;
        prim(1, 0, SIZE_WORD, 24'h004010, 32'h0);
        prim(1, 0, SIZE_WORD, 24'h003000, 32'h0);
        sreq = '{rd: 1'b1, addr: 24'h003000};
        check("data flash", crb, {16'h0000, FD});
        idle;
        check("hole primary", crb, 32'h0);
        check("hole secondary", {16'h0000, srb}, 32'h0);
        $display("test_flash_hole done");
    endtask : test_flash_hole

    task automatic test_flash_path;
        prog(0, 1, 21'h000200, 32'h1111ABCD);
        check("pflash wr", {freq.wr, freq.prog_space, 6'h0, freq.addr}, 32'hC0000200);
        check("pflash data", {16'h0000, freq.wdata}, 32'h0000ABCD);
        prim(0, 1, SIZE_WORD, 24'h004020, 32'h2222BEEF);
        check("dflash wr", {freq.wr, freq.prog_space, 6'h0, freq.addr}, 32'h80004020);
        check("dflash data", {16'h0000, freq.wdata}, 32'h0000BEEF);
        check("flash not periph", {30'h0, pbus.wr, pbus.rd}, 32'h0);
        prim(1, 0, SIZE_WORD, 24'h004010, 32'h0);
        sreq = '{rd: 1'b1, addr: 24'h004030};
        idle;
        check("flash primary wins", crb, {16'h0000, FD});
        check("secondary loses", {16'h0000, srb}, 32'h0);
        @(negedge clk);
        sreq = '{rd: 1'b1, addr: 24'h004030};
        idle;
        check("secondary flash", {16'h0000, srb}, {16'h0000, FD});
        $display("test_flash_path done");
    endtask : test_flash_path

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // Tests need well under a hundred cycles; this leaves ample margin
    initial begin
        #10000;
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        test_ram();
        test_byte();
        test_periph();
        test_program();
        test_flash_hole();
        test_flash_path();
        end_sim();
    end
endmodule : core_memory_bus_fabric_tb
